// [design/cea_pkg.sv]
package cea_pkg;

   // Address, vector, count and reset constants.
   localparam logic [15:0] CEA_RESET_VEC_HI   = 16'hFFFE;
   localparam logic [15:0] CEA_RESET_VEC_LO   = 16'hFFFF;
   localparam logic [15:0] CEA_POSTINC_STEP   = 16'h0001;
   localparam int          CEA_MASK_BIT       = 3;
   localparam int          CEA_RESET_CYCLES   = 6;
   localparam int          CEA_QUEUE_FILL     = 3;
   localparam int          CEA_STACK_BYTES    = 5;
   localparam logic [15:0] CEA_SP_RESET       = 16'h00FF;
   localparam logic [7:0]  CEA_CCR_RESET      = 8'h08;

   // Addressing modes served by the address former.
   typedef enum logic [1:0] {
      CEA_IDX_OFF8_POSTINC = 2'h0,
      CEA_IDX_OFF16        = 2'h1,
      CEA_STK_OFF8         = 2'h2,
      CEA_STK_OFF16        = 2'h3
   } cea_amode_t;

   // Bus request issued by the sequencer.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } cea_bus_t;

   // CPU register snapshot handed in for stacking.
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0]  x;
      logic [7:0]  a;
      logic [7:0]  condition_code_register;
   } cea_regs_t;

   // Sequencer states, Gray coded along the entry path.
   typedef enum logic [3:0] {
      CEA_S_RESET  = 4'h0,
      CEA_S_RVEC   = 4'h1,
      CEA_S_RUN    = 4'h3,
      CEA_S_STACK  = 4'h2,
      CEA_S_VECHI  = 4'h6,
      CEA_S_VECLO  = 4'h7,
      CEA_S_FREE   = 4'h5,
      CEA_S_FILL   = 4'h4,
      CEA_S_WAIT   = 4'hC,
      CEA_S_STOP   = 4'hD,
      CEA_S_ENTER_BACKGROUND_INSTR   = 4'hF
   } cea_state_t;

endpackage

// [design/cea_sequencer.sv]
// Behaviour
// - Indexed off8 post-increment: address is index plus unsigned byte, index then plus one.
// - Indexed off16: address is index plus 16-bit offset, index unchanged.
// - Stack off8: address is stack pointer plus unsigned byte offset.
// - Stack off16: address is stack pointer plus 16-bit offset.
// - Any reset aborts current activity at once, not at instruction boundary.
// - Reset ends only after source determination completes and the pin is released.
// - After reset, six cycles fetch vector from top two addresses and fill queue.
// - Interrupts are taken at an instruction boundary; saved PC is next instruction.
// - Vector is the software interrupt's when one is requested; otherwise from highest pending interrupt at entry start.
// - Entry stacks PC low, PC high, index low, accumulator, condition codes.
// - Mask bit is set after condition codes are stacked, before service code.
// - Then vector high, vector low, one free cycle, three queue fetches.
// - Entry never stacks the index high byte.
// - Software interrupt uses same entry, ignores mask, synchronous with execution.
// - Wait clears mask bit then gates CPU clocks until interrupt or reset.
// - Interrupt or reset in wait restarts clocks and is processed normally.
// - Background command in wait restarts clocks and enters active background mode.
// - Stop halts all clocks unless configured to keep a minimal set running or debug enable is set.
// - With debug enable set, stop keeps the oscillator running.
// - With debug enable set in stop, background command enters active background mode.
// - Enter-background instruction stops user execution and enters background mode.
// - Background mode left only by reset or the resume command.
// - The mask is bit three of the condition code register.
`timescale 1ns/100ps
`default_nettype none
module cea_sequencer
   import cea_pkg::*;
#(
   parameter int IRQ_N = 8
) (
   input  wire logic             CLK_SYS_I,
   input  wire logic             RST_B_I,
   input  wire logic             SRC_DET_DONE_I,
   input  wire logic             RST_PIN_B_I,
   input  wire cea_amode_t       AMODE_I,
   input  wire logic [7:0]       OFF8_I,
   input  wire logic [15:0]      OFF16_I,
   input  wire logic             IDX_FETCH_DONE_I,
   input  wire logic             INSTR_BOUNDARY_I,
   input  wire cea_regs_t        REGS_I,
   input  wire logic [IRQ_N-1:0] IRQ_I,
   input  wire logic             SWI_I,
   input  wire logic             WAIT_I,
   input  wire logic             STOP_I,
   input  wire logic             ENTER_BACKGROUND_INSTR_I,
   input  wire logic             STOP_KEEP_CLK_I,
   input  wire logic             DBG_DEBUG_ENABLE_BIT_SET_I,
   input  wire logic             DBG_BACKGROUND_CMD_I,
   input  wire logic             DBG_RESUME_CMD_I,
   input  wire logic             BUS_RDY_I,
   input  wire logic [7:0]       BUS_RDATA_I,
   output logic [15:0]           EA_O,
   output logic [15:0]           HX_O,
   output logic [15:0]           SP_O,
   output logic [7:0]            CCR_O,
   output cea_bus_t              BUS_O,
   output logic [15:0]           PC_O,
   output logic                  PC_LOAD_O,
   output logic                  CPU_CLK_EN_O,
   output logic                  OSC_EN_O,
   output logic                  MIN_CLK_EN_O,
   output logic                  ENTER_BACKGROUND_INSTR_ACTIVE_O,
   output logic                  DEBUG_EN_O,
   output logic                  QUEUE_FILL_O
);

   // Highest pending source is the lowest index; vectors descend from below reset.
   function automatic logic [15:0] cea_vec_hi(input logic [IRQ_N-1:0] irq, input logic software_interrupt_instr);
      logic [15:0] v;
      v = CEA_RESET_VEC_HI - 16'h0002;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         if (irq[i]) begin
            v = CEA_RESET_VEC_HI - 16'(2 * (i + 2));
         end
      end
      if (software_interrupt_instr) begin
         v = CEA_RESET_VEC_HI - 16'h0002;
      end
      return v;
   endfunction

   cea_state_t  st_r, st_nxt;
   logic [15:0] hx_r, hx_nxt;
   logic [15:0] sp_r, sp_nxt;
   logic [7:0]  ccr_r, ccr_nxt;
   logic [15:0] vec_r, vec_nxt;
   logic [15:0] pc_r, pc_nxt;
   logic [15:0] ea_r, ea_nxt;
   logic [2:0]  cnt_r, cnt_nxt;
   logic        dben_r, dben_nxt;
   logic        enter_background_instr_r;
   logic        irq_take;
   logic [39:0] stack_bytes;
   cea_bus_t    bus_nxt, bus_r;
   logic        bus_stall;

   // Bytes in stacking order; the index high byte is left out on purpose.
   assign stack_bytes = {REGS_I.pc[7:0], REGS_I.pc[15:8], REGS_I.x, REGS_I.a, ccr_r};
   assign irq_take    = INSTR_BOUNDARY_I && ((|IRQ_I && !ccr_r[CEA_MASK_BIT]) || SWI_I);

   // The request leaves through a flip-flop, so the cycle in which BUS_O shows it is the one
   // in which the far side answers. A request not yet taken is held as it stands, and no
   // state but CEA_S_RVEC issues anything new until the bus is free; read data is taken in that same cycle.
   // The trade is one cycle of latency for a bus with no combinational path from state to pins.
   assign bus_stall = bus_r.valid && !BUS_RDY_I;

   // Next-state logic for the whole sequencer and the address former.
   always_comb begin
      st_nxt   = st_r;
      hx_nxt   = hx_r;
      sp_nxt   = sp_r;
      ccr_nxt  = ccr_r;
      vec_nxt  = vec_r;
      pc_nxt   = pc_r;
      ea_nxt   = ea_r;
      cnt_nxt  = cnt_r;
      dben_nxt = dben_r || DBG_DEBUG_ENABLE_BIT_SET_I;
      // A request that has not been taken stays on the bus unchanged.
      bus_nxt  = bus_stall ? bus_r : cea_bus_t'('0);
      // Effective address forming; the full 16-bit sum wraps like the address bus.
      case (AMODE_I)
         CEA_IDX_OFF8_POSTINC: ea_nxt = hx_r + {8'h00, OFF8_I};
         CEA_IDX_OFF16:        ea_nxt = hx_r + OFF16_I;
         CEA_STK_OFF8:         ea_nxt = sp_r + {8'h00, OFF8_I};
         CEA_STK_OFF16:        ea_nxt = sp_r + OFF16_I;
         default:              ea_nxt = hx_r;
      endcase
      if (IDX_FETCH_DONE_I && AMODE_I == CEA_IDX_OFF8_POSTINC) begin
         hx_nxt = hx_r + CEA_POSTINC_STEP;
      end
      // Sequencer proper. Entry states only move on when the bus slot is free, so a slow
      // memory stretches an entry sequence without ever reordering it.
      case (st_r)
         CEA_S_RESET: begin
            if (SRC_DET_DONE_I && RST_PIN_B_I) begin
               st_nxt  = CEA_S_RVEC;
               cnt_nxt = 3'h0;
            end
         end
         CEA_S_RVEC: begin
            // Six fixed cycles: vector high, vector low, free, three queue fetches.
            // Each read is issued one cycle before its byte is taken, since the request
            // stands on the bus only after it has passed the output flip-flop.
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h0) begin
               bus_nxt = '{valid: 1'b1, write: 1'b0, addr: CEA_RESET_VEC_HI, wdata: 8'h00};
            end else if (cnt_r == 3'h1) begin
               bus_nxt = '{valid: 1'b1, write: 1'b0, addr: CEA_RESET_VEC_LO, wdata: 8'h00};
               vec_nxt = {BUS_RDATA_I, 8'h00};
            end else if (cnt_r == 3'h2) begin
               vec_nxt = {vec_r[15:8], BUS_RDATA_I};
               pc_nxt  = {vec_r[15:8], BUS_RDATA_I};
            end else begin
               bus_nxt = '{valid: 1'b1, write: 1'b0, addr: pc_r, wdata: 8'h00};
               pc_nxt  = pc_r + 16'h0001;
            end
            if (cnt_r == 3'(CEA_RESET_CYCLES - 1)) begin
               st_nxt = dben_r && enter_background_instr_r ? CEA_S_ENTER_BACKGROUND_INSTR : CEA_S_RUN;
            end
         end
         CEA_S_RUN: begin
            // Background wins over a pending request so a breakpoint is never skipped.
            if (ENTER_BACKGROUND_INSTR_I) begin
               st_nxt = CEA_S_ENTER_BACKGROUND_INSTR;
            end else if (irq_take) begin
               st_nxt  = CEA_S_STACK;
               vec_nxt = cea_vec_hi(IRQ_I, SWI_I);
               cnt_nxt = 3'h0;
            end else if (WAIT_I) begin
               ccr_nxt[CEA_MASK_BIT] = 1'b0;
               st_nxt = CEA_S_WAIT;
            end else if (STOP_I) begin
               st_nxt = CEA_S_STOP;
            end
         end
         CEA_S_STACK: begin
            // One write per free bus slot; the stack pointer moves with each issued byte.
            if (!bus_stall) begin
               bus_nxt = '{valid: 1'b1, write: 1'b1, addr: sp_r,
                           wdata: stack_bytes[39 - 8 * cnt_r -: 8]};
               sp_nxt  = sp_r - 16'h0001;
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == 3'(CEA_STACK_BYTES - 1)) begin
                  st_nxt = CEA_S_VECHI;
               end
            end
         end
         CEA_S_VECHI: begin
            // The condition code write stands on the bus now; once it is taken the mask goes up,
            // so no maskable request can slip in before the service code runs.
            if (!bus_stall) begin
               ccr_nxt[CEA_MASK_BIT] = 1'b1;
               bus_nxt = '{valid: 1'b1, write: 1'b0, addr: vec_r, wdata: 8'h00};
               st_nxt  = CEA_S_VECLO;
            end
         end
         CEA_S_VECLO: begin
            // The high vector read is on the bus in this cycle, so its byte is taken here.
            if (!bus_stall) begin
               pc_nxt[15:8] = BUS_RDATA_I;
               bus_nxt = '{valid: 1'b1, write: 1'b0, addr: vec_r + 16'h0001, wdata: 8'h00};
               st_nxt  = CEA_S_FREE;
            end
         end
         CEA_S_FREE: begin
            // The low vector byte lands while the next bus slot is left empty.
            if (!bus_stall) begin
               pc_nxt[7:0] = BUS_RDATA_I;
               st_nxt  = CEA_S_FILL;
               cnt_nxt = 3'h0;
            end
         end
         CEA_S_FILL: begin
            // Three prefetches refill the queue; the last is still on the bus as RUN begins.
            if (!bus_stall) begin
               bus_nxt = '{valid: 1'b1, write: 1'b0, addr: pc_r, wdata: 8'h00};
               pc_nxt  = pc_r + 16'h0001;
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == 3'(CEA_QUEUE_FILL - 1)) begin
                  st_nxt = CEA_S_RUN;
               end
            end
         end
         CEA_S_WAIT: begin
            // A host command is checked first so a debugger can always reach a sleeping core.
            if (DBG_BACKGROUND_CMD_I) begin
               st_nxt = CEA_S_ENTER_BACKGROUND_INSTR;
            end else if (|IRQ_I) begin
               st_nxt  = CEA_S_STACK;
               vec_nxt = cea_vec_hi(IRQ_I, 1'b0);
               cnt_nxt = 3'h0;
            end
         end
         CEA_S_STOP: begin
            // Without the kept clock set no interrupt is seen, so only reset or a background command with debug enabled wakes it.
            if (DBG_BACKGROUND_CMD_I && dben_r) begin
               st_nxt = CEA_S_ENTER_BACKGROUND_INSTR;
            end else if (|IRQ_I && STOP_KEEP_CLK_I) begin
               st_nxt  = CEA_S_STACK;
               vec_nxt = cea_vec_hi(IRQ_I, 1'b0);
               cnt_nxt = 3'h0;
            end
         end
         CEA_S_ENTER_BACKGROUND_INSTR: begin
            // Debug stays enabled once the host has taken control.
            dben_nxt = 1'b1;
            if (DBG_RESUME_CMD_I) begin
               st_nxt = CEA_S_RUN;
            end
         end
         default: st_nxt = CEA_S_RESET;
      endcase
   end

   // Asynchronous reset drops everything at once, mid-instruction included.
   // A half-stacked entry is simply abandoned; nothing is replayed after release.
   always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st_r   <= CEA_S_RESET;
         hx_r   <= 16'h0000;
         sp_r   <= CEA_SP_RESET;
         ccr_r  <= CEA_CCR_RESET;
         vec_r  <= 16'h0000;
         pc_r   <= 16'h0000;
         ea_r   <= 16'h0000;
         cnt_r  <= 3'h0;
         dben_r <= 1'b0;
         bus_r  <= '0;
      end else begin
         st_r   <= st_nxt;
         hx_r   <= hx_nxt;
         sp_r   <= sp_nxt;
         ccr_r  <= ccr_nxt;
         vec_r  <= vec_nxt;
         pc_r   <= pc_nxt;
         ea_r   <= ea_nxt;
         cnt_r  <= cnt_nxt;
         dben_r <= dben_nxt;
         bus_r  <= bus_nxt;
      end
   end

   // Reset into background is requested by the debug enable strap at the last reset vector cycle.
   assign enter_background_instr_r = DBG_DEBUG_ENABLE_BIT_SET_I;

   // Clock gating outputs; the oscillator survives stop when debug is enabled or the kept clock is set.
   assign CPU_CLK_EN_O  = !(st_r == CEA_S_WAIT || st_r == CEA_S_STOP);
   assign OSC_EN_O      = st_r != CEA_S_STOP || dben_r || STOP_KEEP_CLK_I;
   assign MIN_CLK_EN_O  = st_r != CEA_S_STOP || STOP_KEEP_CLK_I;
   assign ENTER_BACKGROUND_INSTR_ACTIVE_O = st_r == CEA_S_ENTER_BACKGROUND_INSTR;
   assign DEBUG_EN_O    = dben_r;
   assign QUEUE_FILL_O  = st_r == CEA_S_FILL;
   assign PC_LOAD_O     = st_r == CEA_S_FREE;
   assign EA_O          = ea_r;
   assign HX_O          = hx_r;
   assign SP_O          = sp_r;
   assign CCR_O         = ccr_r;
   assign PC_O          = pc_r;
   assign BUS_O         = bus_r;

endmodule
`default_nettype wire

// [tb/cea_partner.sv]
`timescale 1ns/100ps
`default_nettype none
// Far side: reset-source logic, the reset pin and a memory that accepts every request at once.
module cea_partner
   import cea_pkg::*;
(
   input  wire logic     clk_i,
   input  wire logic     rst_b_i,
   input  wire logic     pin_hold_i,
   input  wire cea_bus_t bus_i,
   output logic          src_done_o,
   output logic          pin_b_o,
   output logic          rdy_o,
   output logic [7:0]    rdata_o
);
   logic [2:0] det_cnt;
   logic [7:0] last_rdata;
   // Source determination needs a few cycles after each reset, so the sequencer has to wait for it.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         det_cnt    <= 3'h0;
         last_rdata <= 8'h00;
      end else begin
         det_cnt    <= (det_cnt == 3'h7) ? det_cnt : det_cnt + 3'h1;
         last_rdata <= rdata_o;
      end
   end
   // Read data folds the address; off a read the line shows the inverse of the last byte, not a held value.
   assign src_done_o = (det_cnt == 3'h7);
   assign pin_b_o    = !pin_hold_i;
   assign rdy_o      = 1'b1;
   assign rdata_o    = (bus_i.valid && !bus_i.write) ? (bus_i.addr[15:8] ^ bus_i.addr[7:0]) : ~last_rdata;
endmodule
`default_nettype wire

// [tb/cea_sequencer_checker.sv]
`timescale 1ns/100ps
`default_nettype none
// Port-level watch on address forming, interrupt entry order and the low-power and debug states.
module cea_sequencer_checker
   import cea_pkg::*;
#(
   parameter int IRQ_N = 8
) (
   input wire logic        CLK_SYS_I,
   input wire logic        RST_B_I,
   input wire cea_amode_t  AMODE_I,
   input wire logic [7:0]  OFF8_I,
   input wire logic [15:0] OFF16_I,
   input wire logic        IDX_FETCH_DONE_I,
   input wire logic        DBG_RESUME_CMD_I,
   input wire logic [15:0] EA_O,
   input wire logic [15:0] HX_O,
   input wire logic [15:0] SP_O,
   input wire logic [7:0]  CCR_O,
   input wire cea_bus_t    BUS_O,
   input wire logic        PC_LOAD_O,
   input wire logic        QUEUE_FILL_O,
   input wire logic        CPU_CLK_EN_O,
   input wire logic        OSC_EN_O,
   input wire logic        ENTER_BACKGROUND_INSTR_ACTIVE_O,
   input wire logic        DEBUG_EN_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_B_I);
   // Five stack writes in a row, then a read; a sixth write would mean the index high byte was stacked.
   sequence stack_s;
      (BUS_O.valid && BUS_O.write) [*5] ##1 (BUS_O.valid && !BUS_O.write);
   endsequence
   sequence fill_s;
      QUEUE_FILL_O [*3];
   endsequence
   ea_idx8_a: assert property (AMODE_I == CEA_IDX_OFF8_POSTINC |=> EA_O == $past(HX_O) + $past(OFF8_I))
      else $error("indexed byte offset address wrong");
   post_inc_a: assert property (IDX_FETCH_DONE_I && AMODE_I == CEA_IDX_OFF8_POSTINC |=> HX_O == $past(HX_O) + 16'h0001)
      else $error("index not stepped after fetch");
   hx_hold_a: assert property (IDX_FETCH_DONE_I && AMODE_I != CEA_IDX_OFF8_POSTINC |=> $stable(HX_O))
      else $error("index changed without post increment");
   ea_idx16_a: assert property (AMODE_I == CEA_IDX_OFF16 |=> EA_O == $past(HX_O) + $past(OFF16_I))
      else $error("indexed word offset address wrong");
   ea_stk8_a: assert property (AMODE_I == CEA_STK_OFF8 |=> EA_O == $past(SP_O) + $past(OFF8_I))
      else $error("stack byte offset address wrong");
   ea_stk16_a: assert property (AMODE_I == CEA_STK_OFF16 |=> EA_O == $past(SP_O) + $past(OFF16_I))
      else $error("stack word offset address wrong");
   stack_order_a: assert property ($rose(BUS_O.valid && BUS_O.write) |-> stack_s)
      else $error("stacking not five writes then vector read");
   entry_fill_a: assert property ($fell(PC_LOAD_O) |-> CCR_O[CEA_MASK_BIT] ##0 fill_s)
      else $error("mask or queue refill wrong after free cycle");
   osc_keep_a: assert property (DEBUG_EN_O && !CPU_CLK_EN_O |-> OSC_EN_O)
      else $error("oscillator stopped with debug enabled");
   enter_background_instr_hold_a: assert property (ENTER_BACKGROUND_INSTR_ACTIVE_O && !DBG_RESUME_CMD_I |=> ENTER_BACKGROUND_INSTR_ACTIVE_O)
      else $error("background left without resume");
endmodule
bind cea_sequencer cea_sequencer_checker #(.IRQ_N(IRQ_N)) cea_sequencer_checker_inst (.CLK_SYS_I, .RST_B_I,
   .AMODE_I, .OFF8_I, .OFF16_I, .IDX_FETCH_DONE_I, .DBG_RESUME_CMD_I, .EA_O, .HX_O, .SP_O, .CCR_O, .BUS_O,
   .PC_LOAD_O, .QUEUE_FILL_O, .CPU_CLK_EN_O, .OSC_EN_O, .ENTER_BACKGROUND_INSTR_ACTIVE_O, .DEBUG_EN_O);
`default_nettype wire

// [tb/cea_sequencer_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module cpu_exception_and_addressing_sequencer_tb_top
   import cea_pkg::*;
();
   logic        clk = 1'b0, rst_b = 1'b1, hold = 1'b0, mon_on = 1'b0, fetch = 1'b0, bnd = 1'b0;
   logic        software_interrupt_instr = 1'b0, wt = 1'b0, stp = 1'b0, bgi = 1'b0, keep = 1'b0, debug_enable_bit = 1'b0, bgcmd = 1'b0, resume = 1'b0;
   cea_amode_t  amode = CEA_IDX_OFF16;
   logic [7:0]  off8 = 8'h00, irq = 8'h00, rdata, condition_code_register;
   logic [15:0] off16 = 16'h0000, n_inc = 16'h0000, ea, hx, sp, pc;
   cea_regs_t   regs = '0;
   cea_bus_t    bus;
   logic        src_done, pin_b, rdy, program_counter_low, cen, osc, minc, bga, dben, qf;
   logic [24:0] expq[$], got_e;
   int          num_errors = 0, checks = 0;
   // Free-running 50 MHz system clock.
   always #10 clk = ~clk;
   cea_sequencer #(.IRQ_N(8)) cea_sequencer_inst (
      .CLK_SYS_I(clk), .RST_B_I(rst_b), .SRC_DET_DONE_I(src_done), .RST_PIN_B_I(pin_b), .AMODE_I(amode),
      .OFF8_I(off8), .OFF16_I(off16), .IDX_FETCH_DONE_I(fetch), .INSTR_BOUNDARY_I(bnd), .REGS_I(regs),
      .IRQ_I(irq), .SWI_I(software_interrupt_instr), .WAIT_I(wt), .STOP_I(stp), .ENTER_BACKGROUND_INSTR_I(bgi), .STOP_KEEP_CLK_I(keep),
      .DBG_DEBUG_ENABLE_BIT_SET_I(debug_enable_bit), .DBG_BACKGROUND_CMD_I(bgcmd), .DBG_RESUME_CMD_I(resume), .BUS_RDY_I(rdy),
      .BUS_RDATA_I(rdata), .EA_O(ea), .HX_O(hx), .SP_O(sp), .CCR_O(condition_code_register), .BUS_O(bus), .PC_O(pc),
      .PC_LOAD_O(program_counter_low), .CPU_CLK_EN_O(cen), .OSC_EN_O(osc), .MIN_CLK_EN_O(minc), .ENTER_BACKGROUND_INSTR_ACTIVE_O(bga),
      .DEBUG_EN_O(dben), .QUEUE_FILL_O(qf));
   cea_partner cea_partner_inst (.clk_i(clk), .rst_b_i(rst_b), .pin_hold_i(hold), .bus_i(bus),
      .src_done_o(src_done), .pin_b_o(pin_b), .rdy_o(rdy), .rdata_o(rdata));
   // Each accepted bus cycle is matched against the oldest note; a cycle with nothing noted is a fault.
   always @(posedge clk) begin
      if (mon_on && bus.valid && rdy) begin
         if (expq.size() == 0) begin
            `CHK("spare bus cycle", 1'b0, 1'b1)
         end else begin
            got_e = expq.pop_front();
            `CHK("bus cycle", got_e, {bus.write, bus.addr, bus.write ? bus.wdata : 8'h00})
         end
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // Decoder and host pulses come with an instruction boundary so the sequencer may take them.
   task automatic pulse(ref logic s);
      s = 1'b1;
      bnd = 1'b1;
      cyc(1);
      s = 1'b0;
      bnd = 1'b0;
   endtask
   task automatic expect_entry(input logic [15:0] vec, input logic [15:0] sp0, input logic [7:0] ccr0);
      logic [15:0] isr;
      isr = {vec[15:8] ^ vec[7:0], vec[15:8] ^ (vec[7:0] + 8'h01)};
      expq = '{{1'b1, sp0, regs.pc[7:0]}, {1'b1, sp0 - 16'h0001, regs.pc[15:8]}, {1'b1, sp0 - 16'h0002, regs.x},
         {1'b1, sp0 - 16'h0003, regs.a}, {1'b1, sp0 - 16'h0004, ccr0}, {1'b0, vec, 8'h00},
         {1'b0, vec + 16'h0001, 8'h00}, {1'b0, isr, 8'h00}, {1'b0, isr + 16'h0001, 8'h00}, {1'b0, isr + 16'h0002, 8'h00}};
   endtask
   task automatic drain();
      for (int i = 0; i < 100 && expq.size() != 0; i++) begin
         cyc(1);
      end
      `CHK("entry finished", 0, expq.size())
      if (expq.size() != 0) begin
         test_done();
      end
   endtask
   // Reset is checked at once for abort, then with the pin held, then for the vector fetch.
   task automatic reset(input logic h);
      mon_on = 1'b0;
      rst_b = 1'b0;
      hold = h;
      #1;
      `CHK("bus idle in reset", 1'b0, bus.valid)
      `CHK("clocks run in reset", 1'b1, cen)
      `CHK("background off in reset", 1'b0, bga)
      cyc(3);
      rst_b = 1'b1;
      cyc(20);
      // The partner folds FFFE and FFFF into vector 0100; PC then sits past the queue prefetches.
      `CHK("vector while pin held", h ? 16'h0000 : 16'h0100 + 16'(CEA_QUEUE_FILL), pc)
      hold = 1'b0;
      cyc(20);
      `CHK("reset vector", 16'h0100 + 16'(CEA_QUEUE_FILL), pc)
      `CHK("stack pointer reset", CEA_SP_RESET, sp)
      `CHK("condition codes reset", CEA_CCR_RESET, condition_code_register)
      mon_on = 1'b1;
   endtask
   task automatic test_done();
      if (num_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Main sequence: addressing, masked and unmasked entry, wait, stop and background paths.
   initial begin
      void'($urandom(32'h3aa7f47c));
      {regs.pc, regs.x, regs.a} = 32'($urandom());
      #2;
      reset(1'b0);
      repeat (64) begin
         amode = cea_amode_t'(2'($urandom_range(3)));
         {off16, off8} = 24'($urandom());
         fetch = 1'($urandom());
         n_inc = n_inc + {15'h0000, fetch && amode == CEA_IDX_OFF8_POSTINC};
         cyc(1);
      end
      fetch = 1'b0;
      `CHK("index after post increments", n_inc, hx)
      irq = 8'h01;
      bnd = 1'b1;
      cyc(1);
      bnd = 1'b0;
      cyc(10);
      irq = 8'h00;
      expect_entry(16'hFFFC, CEA_SP_RESET, CEA_CCR_RESET);
      pulse(software_interrupt_instr);
      drain();
      `CHK("stack pointer after entry", CEA_SP_RESET - 16'h0005, sp)
      pulse(wt);
      cyc(2);
      `CHK("clocks gated in wait", 1'b0, cen)
      `CHK("mask cleared by wait", 1'b0, condition_code_register[CEA_MASK_BIT])
      expect_entry(16'hFFF6, CEA_SP_RESET - 16'h0005, 8'h00);
      irq = 8'h24;
      bnd = 1'b1;
      drain();
      irq = 8'h00;
      bnd = 1'b0;
      `CHK("clocks back after wake", 1'b1, cen)
      pulse(stp);
      cyc(2);
      `CHK("clocks off in stop", 1'b0, cen)
      `CHK("oscillator off in stop", 1'b0, osc)
      pulse(bgcmd);
      cyc(2);
      `CHK("background refused in stop", 1'b0, bga)
      reset(1'b1);
      keep = 1'b1;
      pulse(stp);
      cyc(2);
      `CHK("minimal clocks kept", 1'b1, minc)
      `CHK("clocks off in kept stop", 1'b0, cen)
      expect_entry(16'hFFFA, CEA_SP_RESET, CEA_CCR_RESET);
      irq = 8'h01;
      drain();
      irq = 8'h00;
      keep = 1'b0;
      reset(1'b0);
      pulse(debug_enable_bit);
      cyc(1);
      `CHK("debug enable", 1'b1, dben)
      pulse(stp);
      cyc(2);
      `CHK("oscillator kept for debug", 1'b1, osc)
      pulse(bgcmd);
      cyc(2);
      `CHK("background from stop", 1'b1, bga)
      `CHK("clocks back in background", 1'b1, cen)
      pulse(resume);
      cyc(2);
      `CHK("resumed", 1'b0, bga)
      pulse(wt);
      cyc(2);
      pulse(bgcmd);
      cyc(2);
      `CHK("background from wait", 1'b1, bga)
      pulse(software_interrupt_instr);
      cyc(8);
      pulse(resume);
      cyc(2);
      pulse(bgi);
      cyc(2);
      `CHK("background instruction", 1'b1, bga)
      reset(1'b0);
      test_done();
   end
endmodule
`default_nettype wire
